// ### adc_result_serial_readout.sv
// Result buffer and serial readout of a delta-sigma converter, with power-on sequencing.
// Assumes raw signed samples arrive from a decimator on i_core_clk and that the
// select, shift clock and supply flag are asynchronous pins.
`timescale 1ns/1ps

// Plain synchronous FIFO with registered input ready.
module result_fifo #(
  parameter int unsigned WIDTH = 31,
  parameter int unsigned DEPTH = 32
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_clear,
  // Fill side.
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // Drain side.
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
  localparam logic [AW:0] NEAR_FULL = (AW+1)'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH]; // Storage, no reset needed.
  logic [AW-1:0] wr_ptr; // Next slot to write.
  logic [AW-1:0] rd_ptr; // Oldest slot.
  logic [AW:0] count; // Words held.
  logic push; // Accepted write.
  logic pop; // Accepted read.

  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_out_valid = (count != '0);
  assign o_out_data = mem[rd_ptr];

  // Storage write; pointers wrap since depth is a power of two.
  always_ff @(posedge i_clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  // Pointers, count and a registered ready that drops on reset or clear and otherwise only once the buffer is full.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      o_in_ready <= 1'h0;
    end
    else if (i_clear)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      o_in_ready <= 1'h0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= wr_ptr + 1'h1;
      end
      if (pop)
      begin
        rd_ptr <= rd_ptr + 1'h1;
      end
      // Ready is registered, so it must anticipate the count one cycle ahead.
      if (push && !pop)
      begin
        count <= count + 1'h1;
        o_in_ready <= (count + 1'h1) < FULL_COUNT && count != NEAR_FULL;
      end
      else if (pop && !push)
      begin
        count <= count - 1'h1;
        o_in_ready <= 1'h1;
      end
      else
      begin
        o_in_ready <= (count < FULL_COUNT);
      end
    end
  end
endmodule // result_fifo

// Readout top: power-on sequencing, conversion cycle and serial shifting.
module adc_result_serial_readout #(
  parameter int unsigned POR_LEN = adc_readout_pkg::POR_CYCLES
) (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Supply monitor, high while supply is above threshold.
  input wire logic i_supply_ok,
  // Raw samples from the decimator.
  input wire logic i_raw_valid,
  input wire logic signed [30:0] i_raw,
  output logic o_raw_ready,
  // Modulator control.
  output logic o_conv_start,
  output adc_readout_pkg::conv_cfg_t o_conv_cfg,
  // Serial link pins.
  input wire logic i_device_select_n,
  input wire logic i_clock_source_select,
  input wire logic i_sck,
  output logic o_sck,
  output logic o_sck_oe_n,
  output logic o_serial_out,
  output logic o_serial_out_oe_n
);

  // Two-stage synchronisers for pins; stage one is read only by stage two.
  logic [1:0] sel_sync;
  logic [1:0] src_sync;
  logic [1:0] sck_sync;
  logic [1:0] sup_sync;
  logic sck_prev; // Previous synchronised external clock level.
  logic cs_low; // Select asserted.
  logic ext_rise; // Rising edge of the external clock.
  logic ext_fall; // Falling edge of the external clock.
  logic sck_rise; // Rising edge from the chosen source.
  logic sck_fall; // Falling edge from the chosen source.
  logic [$clog2(POR_LEN+1)-1:0] por_cnt; // Cycles left in the power-on pulse.
  logic por_busy; // Internal reset state.
  adc_readout_pkg::cycle_state_t state; // Readout cycle.
  adc_readout_pkg::cycle_state_t next_state; // Next cycle state.
  logic [31:0] shreg; // Holding shift register.
  logic [5:0] edge_cnt; // Falling edges seen in output state.
  logic [3:0] div_cnt; // Generated clock divider.
  logic gen_rise; // Generated clock about to rise.
  logic gen_fall; // Generated clock about to fall.
  logic gen_run; // Generator allowed to run.
  logic fifo_valid; // A finished result waits.
  // Signed, so that the range compares below treat negative samples as negative.
  logic signed [30:0] fifo_data; // Oldest raw result.
  logic take; // Conversion completes now.
  logic signed [30:0] clamped; // Range-limited result.
  logic [31:0] word; // Assembled result word.
  logic next_sdo; // Next serial output level.

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sel_sync <= 2'h3;
      src_sync <= 2'h0;
      sck_sync <= 2'h0;
      sup_sync <= 2'h0;
      sck_prev <= 1'h0;
    end
    else
    begin
      sel_sync <= {sel_sync[0], i_device_select_n};
      src_sync <= {src_sync[0], i_clock_source_select};
      sck_sync <= {sck_sync[0], i_sck};
      sup_sync <= {sup_sync[0], i_supply_ok};
      sck_prev <= sck_sync[1];
    end
  end

  assign cs_low = !sel_sync[1];
  assign ext_rise = sck_sync[1] && !sck_prev;
  assign ext_fall = !sck_sync[1] && sck_prev;
  // Edges only count while selected; the source pin picks the clock.
  assign sck_rise = cs_low && (src_sync[1] ? gen_rise : ext_rise);
  assign sck_fall = cs_low && (src_sync[1] ? gen_fall : ext_fall);

  // Power-on reset: held while the supply is low, then a fixed-length pulse.
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      por_cnt <= '0;
      por_busy <= 1'h1;
    end
    else if (!sup_sync[1])
    begin
      por_cnt <= ($bits(por_cnt))'(POR_LEN);
      por_busy <= 1'h1;
    end
    else if (por_cnt != '0)
    begin
      por_cnt <= por_cnt - 1'h1;
      por_busy <= 1'h1;
    end
    else
    begin
      por_busy <= 1'h0;
    end
  end

  // Clamp beyond full scale and flip the sign so that zero reads as polarity high.
  always_comb
  begin
    if (fifo_data >= adc_readout_pkg::FS_POS)
    begin
      clamped = adc_readout_pkg::FS_POS + adc_readout_pkg::ONE_LSB;
    end
    else if (fifo_data < adc_readout_pkg::FS_NEG)
    begin
      clamped = adc_readout_pkg::FS_NEG - adc_readout_pkg::ONE_LSB;
    end
    else
    begin
      clamped = fifo_data;
    end
    // Pending low, filler low, then polarity, result and sub-LSBs.
    word = {1'h0, 1'h0, !clamped[29], clamped[28:0]};
  end

  assign take = (state == adc_readout_pkg::ST_CONVERT) && fifo_valid;

  // Cycle sequencing: convert, sleep until a rising edge, then shift out.
  always_comb
  begin
    next_state = state;
    case (state)
      adc_readout_pkg::ST_RESET:
        next_state = adc_readout_pkg::ST_CONVERT;
      adc_readout_pkg::ST_CONVERT:
        if (take)
        begin
          next_state = adc_readout_pkg::ST_SLEEP;
        end
      adc_readout_pkg::ST_SLEEP:
        if (sck_rise)
        begin
          next_state = adc_readout_pkg::ST_OUTPUT;
        end
      default:
        // Select rising aborts; the 32nd falling edge ends the word.
        if (!cs_low || (sck_fall && edge_cnt == adc_readout_pkg::LAST_BIT_EDGE))
        begin
          next_state = adc_readout_pkg::ST_CONVERT;
        end
    endcase
  end

  // State, conversion start pulse and power-on defaults.
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state <= adc_readout_pkg::ST_RESET;
      o_conv_start <= 1'h0;
      o_conv_cfg <= adc_readout_pkg::CFG_DEFAULT;
    end
    else if (por_busy)
    begin
      state <= adc_readout_pkg::ST_RESET;
      o_conv_start <= 1'h0;
      o_conv_cfg <= adc_readout_pkg::CFG_DEFAULT;
    end
    else
    begin
      state <= next_state;
      // A start is issued on every entry into the convert state.
      o_conv_start <= (next_state == adc_readout_pkg::ST_CONVERT)
        && (state != adc_readout_pkg::ST_CONVERT);
    end
  end

  // Holding register and edge counter; between loads the word shifts left on each falling edge in output state.
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      shreg <= '0;
      edge_cnt <= '0;
    end
    else if (por_busy)
    begin
      shreg <= '0;
      edge_cnt <= '0;
    end
    else if (take)
    begin
      shreg <= word;
      edge_cnt <= '0;
    end
    else if (state == adc_readout_pkg::ST_OUTPUT && sck_fall)
    begin
      shreg <= {shreg[30:0], 1'h0};
      edge_cnt <= edge_cnt + 1'h1;
    end
  end

  // Serial output level: pending high, done low, data during output.
  always_comb
  begin
    case (next_state)
      adc_readout_pkg::ST_OUTPUT:
        next_sdo = (state == adc_readout_pkg::ST_OUTPUT && sck_fall) ? shreg[30] : shreg[31];
      adc_readout_pkg::ST_SLEEP:
        next_sdo = 1'h0;
      default:
        next_sdo = 1'h1;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_serial_out <= 1'h1;
      o_serial_out_oe_n <= 1'h1;
    end
    else
    begin
      o_serial_out <= next_sdo;
      o_serial_out_oe_n <= !cs_low;
    end
  end

  // Generated shift clock; runs only while selected in sleep or output.
  assign gen_run = src_sync[1] && cs_low && !por_busy
    && (state == adc_readout_pkg::ST_SLEEP || state == adc_readout_pkg::ST_OUTPUT);
  assign gen_rise = gen_run && div_cnt == adc_readout_pkg::SCK_HALF_LAST && !o_sck;
  assign gen_fall = gen_run && div_cnt == adc_readout_pkg::SCK_HALF_LAST && o_sck;

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      div_cnt <= '0;
      o_sck <= 1'h0;
      o_sck_oe_n <= 1'h1;
    end
    else
    begin
      o_sck_oe_n <= !(src_sync[1] && cs_low);
      if (!gen_run)
      begin
        div_cnt <= '0;
        o_sck <= 1'h0;
      end
      else if (div_cnt == adc_readout_pkg::SCK_HALF_LAST)
      begin
        div_cnt <= '0;
        o_sck <= !o_sck;
      end
      else
      begin
        div_cnt <= div_cnt + 1'h1;
      end
    end
  end

  // Results wait here; a full buffer stalls the decimator through o_raw_ready.
  result_fifo #(
    .WIDTH(adc_readout_pkg::RAW_BITS),
    .DEPTH(adc_readout_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_clear(por_busy),
    .i_in_valid(i_raw_valid),
    .i_in_data(i_raw),
    .o_in_ready(o_raw_ready),
    .o_out_valid(fifo_valid),
    .o_out_data(fifo_data),
    .i_out_ready(take)
  );

  sequence seq_last_fall;
    state == adc_readout_pkg::ST_OUTPUT && cs_low && sck_fall
      && edge_cnt == adc_readout_pkg::LAST_BIT_EDGE;
  endsequence

  // A queued result may finish the next conversion at once, so the high level is
  // only promised in the first cycle after the word, together with one start pulse.
  sequence seq_restart;
    state == adc_readout_pkg::ST_CONVERT && o_serial_out && o_conv_start ##1 !o_conv_start;
  endsequence

  a_word_end: assert property (@(posedge i_core_clk) disable iff (!i_rst_n || por_busy)
    seq_last_fall |=> seq_restart)
    else $error("word end did not restart conversion");
  a_abort_select: assert property (@(posedge i_core_clk) disable iff (!i_rst_n || por_busy)
    state == adc_readout_pkg::ST_OUTPUT && !cs_low |=> state == adc_readout_pkg::ST_CONVERT)
    else $error("select rise did not abort output");
  a_output_hiz: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !cs_low |=> o_serial_out_oe_n)
    else $error("serial output driven while deselected");
  a_filler_low: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    take && !por_busy |=> !shreg[adc_readout_pkg::FILL_POS] && !shreg[adc_readout_pkg::PEND_POS])
    else $error("filler or pending bit high in loaded word");
  a_over_flag: assert property (@(posedge i_core_clk) disable iff (!i_rst_n || por_busy)
    take && $signed(fifo_data) >= adc_readout_pkg::FS_POS |=> shreg[29:28] == 2'h3)
    else $error("overrange not flagged");
  a_under_flag: assert property (@(posedge i_core_clk) disable iff (!i_rst_n || por_busy)
    take && $signed(fifo_data) < adc_readout_pkg::FS_NEG |=> shreg[29:28] == 2'h0)
    else $error("underrange not flagged");
  a_sleep_hold: assert property (@(posedge i_core_clk) disable iff (!i_rst_n || por_busy)
    state == adc_readout_pkg::ST_SLEEP && !sck_rise |=> state == adc_readout_pkg::ST_SLEEP
      && $stable(shreg))
    else $error("sleep left without a rising edge");
  a_pending_flag: assert property (@(posedge i_core_clk) disable iff (!i_rst_n || por_busy)
    state == adc_readout_pkg::ST_CONVERT && !take ##1 state == adc_readout_pkg::ST_CONVERT
      |-> o_serial_out)
    else $error("pending flag low during conversion");
  a_por_hold: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !sup_sync[1] |=> por_busy ##1 state == adc_readout_pkg::ST_RESET)
    else $error("low supply did not hold reset");
  a_por_defaults: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    $fell(por_busy) |-> o_conv_cfg == adc_readout_pkg::CFG_DEFAULT)
    else $error("setup not at defaults after reset");
  a_por_pulse: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    $rose(sup_sync[1]) |-> por_busy [*8])
    else $error("power-on pulse too short");
endmodule // adc_result_serial_readout

// ### adc_readout_pkg.sv
// Constants, state encoding and carrier types for the converter result readout.
// Assumes a single 125 MHz core clock and a supply monitor outside this logic.
package adc_readout_pkg;

  // Core clock period and power-on reset length.
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned POR_TIME_US = 500;
  localparam int unsigned POR_CYCLES = (POR_TIME_US * 1000) / CLK_PERIOD_NS;

  // Half period of the generated shift clock in core cycles.
  localparam int unsigned SCK_HALF_CYCLES = 8;
  localparam logic [3:0] SCK_HALF_LAST = 4'(SCK_HALF_CYCLES - 1);

  // Result word layout.
  localparam int unsigned WORD_BITS = 32;
  localparam int unsigned RAW_BITS = 31;
  localparam int unsigned PEND_POS = 31;
  localparam int unsigned FILL_POS = 30;
  localparam int unsigned POL_POS = 29;
  localparam int unsigned MSB_POS = 28;
  localparam int unsigned LSB_POS = 5;
  localparam logic [5:0] LAST_BIT_EDGE = 6'h1f;
  localparam logic [5:0] WORD_EDGE = 6'h20;

  // Full scale and one result LSB in sub-LSB units of the raw sample.
  localparam logic signed [30:0] FS_POS = 31'sh10000000;
  localparam logic signed [30:0] FS_NEG = -31'sh10000000;
  localparam logic signed [30:0] ONE_LSB = 31'sh20;

  // Result buffer shape.
  localparam int unsigned FIFO_DEPTH = 32;

  // Default conversion setup after power-on reset.
  localparam logic [2:0] DEF_POS_LINE = 3'h0;
  localparam logic [2:0] DEF_NEG_LINE = 3'h1;
  localparam logic [2:0] DEF_REF_PAIR = 3'h0;
  localparam logic [15:0] DEF_OSR = 16'h0100;
  localparam logic DEF_SINGLE_RATE = 1'h1;

  // Readout cycle states, Gray coded from reset through convert, sleep and output.
  typedef enum logic [1:0] {
    ST_RESET = 2'h0,
    ST_CONVERT = 2'h1,
    ST_SLEEP = 2'h3,
    ST_OUTPUT = 2'h2
  } cycle_state_t;

  // Setup handed to the modulator for the next conversion.
  typedef struct packed {
    logic [2:0] input_line_pos;
    logic [2:0] input_line_neg;
    logic [2:0] ref_pair;
    logic [15:0] oversampling_ratio;
    logic single_rate_mode;
  } conv_cfg_t;

  localparam conv_cfg_t CFG_DEFAULT =
    '{DEF_POS_LINE, DEF_NEG_LINE, DEF_REF_PAIR, DEF_OSR, DEF_SINGLE_RATE};

endpackage

// ### host_reader.sv
// Behavioural host that reads result words over the serial link.
// Assumes the bench resolves the shared shift clock and data wires.
`timescale 1ns/1ps

module host_reader (
  // Wires seen by the host.
  input wire logic i_sdo,
  input wire logic i_sck_line,
  // Pins driven by the host.
  output logic o_select_n,
  output logic o_sck
);
  // Select released and shift clock idle low before the first frame.
  initial
  begin
    o_select_n = 1'b1;
    o_sck = 1'b0;
  end

  // Select change, then 200 ns for the device's pin synchronisers.
  task automatic sel(input logic v);
    o_select_n = v;
    #200;
  endtask

  // Shift clock pulses that the device must ignore while deselected.
  task automatic wiggle(input int n);
    repeat (n)
    begin
      #62.5 o_sck = 1'b1;
      #62.5 o_sck = 1'b0;
    end
  endtask

  // Reads nbits, sampling each bit at a rising shift edge.
  task automatic read_word(input logic internal, input int nbits, output logic [31:0] w);
    w = '0;
    for (int i = 31; i > 31 - nbits; i--)
    begin
      if (internal)
      begin
        // The device drives the clock, so wait for its rising edge.
        @(posedge i_sck_line);
        w[i] = i_sdo;
      end
      else
      begin
        w[i] = i_sdo;
        o_sck = 1'b1;
        #62.5 o_sck = 1'b0;
        #62.5;
      end
    end
    if (internal)
      @(negedge i_sck_line);
    #100;
  endtask
endmodule // host_reader

// ### tb.sv
// Self-checking bench for the result readout block.
// Assumes the package and host model are compiled first.
`timescale 1ns/1ps

module tb;
  // Core side stimulus and observation.
  logic clk, rst_n, supply_ok, raw_valid, src_sel, o_raw_ready, o_conv_start;
  logic signed [30:0] raw;
  adc_readout_pkg::conv_cfg_t o_conv_cfg;
  // Link wires.
  logic select_n, host_sck, o_sck, o_sck_oe_n, o_serial_out, o_serial_out_oe_n;
  wire logic sck_line, serial_out;
  int n_errors = 0, total_checks = 0, n_conv = 0, seed = 32'hca85;
  logic signed [30:0] stage_q[$], drain_q[$];
  logic signed [30:0] corners [8];

  // Device drives the clock pin only with its enable low; data floats when released.
  assign sck_line = o_sck_oe_n ? host_sck : o_sck;
  assign serial_out = o_serial_out_oe_n ? 1'bz : o_serial_out;

  adc_result_serial_readout #(.POR_LEN(20)) u_dut (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_supply_ok(supply_ok),
    .i_raw_valid(raw_valid), .i_raw(raw), .o_raw_ready(o_raw_ready),
    .o_conv_start(o_conv_start), .o_conv_cfg(o_conv_cfg),
    .i_device_select_n(select_n), .i_clock_source_select(src_sel),
    .i_sck(sck_line), .o_sck(o_sck), .o_sck_oe_n(o_sck_oe_n),
    .o_serial_out(o_serial_out), .o_serial_out_oe_n(o_serial_out_oe_n));

  host_reader u_host (.i_sdo(serial_out), .i_sck_line(sck_line), .o_select_n(select_n),
    .o_sck(host_sck));

  // 125 MHz core clock.
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Conversion starts are counted so that restarts can be checked.
  always @(posedge clk)
    if (o_conv_start === 1'b1)
      n_conv++;

  // Compares and reports at once.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Expected word: clamp one step past full scale, then polarity and bits 28 to 0.
  function automatic logic [31:0] exp_word(input logic signed [30:0] r);
    logic signed [30:0] c;
    c = r;
    if (r >= adc_readout_pkg::FS_POS)
      c = adc_readout_pkg::FS_POS + adc_readout_pkg::ONE_LSB;
    else if (r < adc_readout_pkg::FS_NEG)
      c = adc_readout_pkg::FS_NEG - adc_readout_pkg::ONE_LSB;
    return {2'h0, ~c[30], c[28:0]};
  endfunction

  // Mostly in-range samples, with an occasional positive raw value of up to twice full scale.
  function automatic logic signed [30:0] rnd();
    logic [31:0] r;
    r = $random(seed);
    if (r[31:29] == 3'h0)
      return r[30:0];
    return {{2{r[28]}}, r[28:0]};
  endfunction

  // Sends all staged samples back to back; valid stays up between them.
  task automatic send();
    int k;
    @(posedge clk);
    while (stage_q.size() > 0)
    begin
      raw <= stage_q[0];
      raw_valid <= 1'b1;
      k = 0;
      do
      begin
        @(posedge clk);
        k++;
      end
      while (o_raw_ready !== 1'b1 && k < 300);
      chk(k < 300, 1'b1);
      drain_q.push_back(stage_q.pop_front());
    end
    raw_valid <= 1'b0;
    @(posedge clk);
  endtask

  // One full conversion and readout; wig keeps select high and toggles the clock meanwhile.
  task automatic do_one(input logic signed [30:0] v, input logic internal, input logic wig);
    logic [31:0] w;
    int c0;
    @(posedge clk) src_sel <= internal;
    u_host.sel(wig);
    if (wig)
      chk(serial_out, 1'bz);
    else
      chk(serial_out, 1'b1);
    c0 = n_conv;
    stage_q.push_back(v);
    if (internal)
      fork
        send();
        u_host.read_word(1'b1, 32, w);
      join
    else
    begin
      send();
      if (wig)
      begin
        u_host.wiggle(5);
        u_host.sel(1'b0);
      end
      repeat (10) @(posedge clk);
      chk(serial_out, 1'b0);
      chk(o_sck_oe_n, 1'b1);
      u_host.read_word(1'b0, 32, w);
    end
    drain_q.delete();
    chk(w, exp_word(v));
    chk(serial_out, 1'b1);
    chk(n_conv, c0 + 1);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Watchdog at 75,000 core cycles, about three times the expected run.
  initial
  begin
    #600000;
    n_errors++;
    wrap_up();
  end

  // Main sequence.
  initial
  begin
    logic [31:0] w, e;
    int c0;
    rst_n = 1'b0;
    supply_ok = 1'b1;
    raw_valid = 1'b0;
    raw = '0;
    src_sel = 1'b0;
    corners = '{31'sh0, -31'sh20, adc_readout_pkg::FS_POS + 31'sh1, 31'sh3fffffff,
      adc_readout_pkg::FS_NEG - 31'sh1, 31'sh40000000,
      adc_readout_pkg::FS_POS - adc_readout_pkg::ONE_LSB, adc_readout_pkg::FS_NEG};
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (40) @(posedge clk);
    chk(n_conv, 1);
    chk(o_conv_cfg, adc_readout_pkg::CFG_DEFAULT);
    // Boundary values, alternating clock source, one with the clock ignored.
    for (int i = 0; i < 8; i++)
      do_one(corners[i], i[0], i == 2);
    for (int i = 0; i < 6; i++)
      do_one(rnd(), i[0], 1'b0);
    // Abort after ten bits by raising select.
    @(posedge clk) src_sel <= 1'b0;
    stage_q.push_back(rnd());
    send();
    e = exp_word(drain_q.pop_front());
    repeat (10) @(posedge clk);
    c0 = n_conv;
    u_host.read_word(1'b0, 10, w);
    chk(w & 32'hffc00000, e & 32'hffc00000);
    u_host.sel(1'b1);
    chk(n_conv, c0 + 1);
    do_one(rnd(), 1'b0, 1'b0);
    // Fill the buffer in sleep until it refuses, then drain it word by word.
    stage_q.push_back(rnd());
    send();
    repeat (32) stage_q.push_back(rnd());
    send();
    chk(o_raw_ready, 1'b0);
    while (drain_q.size() > 0)
    begin
      repeat (10) @(posedge clk);
      e = exp_word(drain_q.pop_front());
      u_host.read_word(1'b0, 32, w);
      chk(w, e);
    end
    // Supply drop loses the held and queued results and restarts with defaults.
    repeat (2) stage_q.push_back(rnd());
    send();
    @(posedge clk) supply_ok <= 1'b0;
    repeat (5) @(posedge clk);
    chk(o_raw_ready, 1'b0);
    c0 = n_conv;
    supply_ok <= 1'b1;
    repeat (10) @(posedge clk);
    chk(o_raw_ready, 1'b0);
    chk(n_conv, c0);
    repeat (30) @(posedge clk);
    chk(n_conv, c0 + 1);
    chk(o_conv_cfg, adc_readout_pkg::CFG_DEFAULT);
    drain_q.delete();
    do_one(rnd(), 1'b0, 1'b0);
    wrap_up();
  end
endmodule // tb
